// file: core/rcf_pkg.sv
// Purpose: shared constants for the reset cause flags and clock select block
// Assumes: 16-bit cause register mapped into 32-bit AXI4-Lite words
// Notes: bit positions other than the two lowest flags are local choices
// =============================================================
// package
package rcf_pkg;
  // address decode width of the register slave
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_CLKSTAT = 8'h04;
  // cause register bit positions
  localparam int B_POR = 0;
  localparam int B_BROWN = 1;
  localparam int B_IDLE = 2;
  localparam int B_SLEEP = 3;
  localparam int B_WDOG_TO = 4;
  localparam int B_SWDT = 5;
  localparam int B_SOFT_RST = 6;
  localparam int B_EXTR = 7;
  localparam int B_CFGM = 8;
  localparam int B_ILLOP = 9;
  localparam int B_DEEP = 10;
  localparam int B_TRAP = 15;
  // value after power-on reset: power-on and brown-out flags set
  localparam logic [15:0] CAUSE_RST = 16'h0003;
  // implemented bits; the rest read as zero
  localparam logic [15:0] CAUSE_MASK = 16'h87FF;
  // clock status register fields
  localparam int B_OSC_LO = 0;
  localparam int B_SWEN = 4;
  localparam int B_WDRUN = 5;
  localparam logic [2:0] OSC_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // clock select sequencing
  typedef enum logic [0:0] {
    RCF_CS_LOAD = 1'b0,
    RCF_CS_RUN = 1'b1
  } rcf_cs_state_t;
endpackage : rcf_pkg

// file: core/rcf_if.sv
// Purpose: carriers between the top and its register slave and clock selector
// Assumes: all signals on aclk
// Notes: read data and responses are combinational from the register side
`timescale 1ns/1ps
// =============================================================
// register access carrier
interface rcf_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport slv (output wr_en, output wr_addr, output wdata, output wstrb, input wr_ok,
               output rd_addr, input rd_data, input rd_ok);
  modport regs (input wr_en, input wr_addr, input wdata, input wstrb, output wr_ok,
                input rd_addr, output rd_data, output rd_ok);
endinterface : rcf_reg_if

// =============================================================
// clock select carrier
interface rcf_clk_if;
  logic brown_evt;
  logic warm_evt;
  logic sw_en;
  logic [2:0] fuse_osc;
  logic [2:0] cur_osc;
  logic [2:0] osc_sel;
  modport top (output brown_evt, output warm_evt, output sw_en, output fuse_osc,
               output cur_osc, input osc_sel);
  modport sel (input brown_evt, input warm_evt, input sw_en, input fuse_osc,
               input cur_osc, output osc_sel);
endinterface : rcf_clk_if

// file: core/rcf_axil.sv
// Purpose: AXI4-Lite slave front end for the cause register block
// Assumes: one write and one read outstanding at most
// Notes: write answers 2 edges after both halves are taken, read 1 edge
`timescale 1ns/1ps
module rcf_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  rcf_reg_if.slv rif
);
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;

  // =============================================================
  // write path: address and data taken in either order
  assign awready = !aw_full_q && !bvalid;
  assign wready = !w_full_q && !bvalid;
  assign wr_fire = aw_full_q && w_full_q && !bvalid;
  assign rif.wr_en = wr_fire;
  assign rif.wr_addr = awaddr_q;
  assign rif.wdata = wdata_q;
  assign rif.wstrb = wstrb_q;

  // address half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  // data half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  // response stands until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= rcf_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= rif.wr_ok ? rcf_pkg::RESP_OKAY : rcf_pkg::RESP_DECERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // =============================================================
  // read path: data sampled at the address handshake
  assign arready = !rvalid;
  assign rif.rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rcf_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rif.rd_data;
      rresp <= rif.rd_ok ? rcf_pkg::RESP_OKAY : rcf_pkg::RESP_DECERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : rcf_axil

// file: core/rcf_clksel.sv
// Purpose: picks the system clock source after each kind of reset
// Assumes: fuse and current oscillator fields are stable on aclk
// Notes: power-on load happens on the first edge after reset release
`timescale 1ns/1ps
module rcf_clksel (
  input wire logic aclk,
  input wire logic aresetn,
  rcf_clk_if.sel cif
);
  rcf_pkg::rcf_cs_state_t state_q;
  logic [2:0] osc_q;

  assign cif.osc_sel = osc_q;

  // =============================================================
  // first edge after release loads the fuses; fuses are not sampled in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= rcf_pkg::RCF_CS_LOAD;
    end else begin
      unique case (state_q)
        rcf_pkg::RCF_CS_LOAD: state_q <= rcf_pkg::RCF_CS_RUN;
        rcf_pkg::RCF_CS_RUN: state_q <= rcf_pkg::RCF_CS_RUN;
      endcase
    end
  end

  // source selection by reset type
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q <= rcf_pkg::OSC_RST;
    end else if (state_q == rcf_pkg::RCF_CS_LOAD || cif.brown_evt) begin
      osc_q <= cif.fuse_osc;
    end else if (cif.warm_evt) begin
      osc_q <= cif.sw_en ? cif.cur_osc : cif.fuse_osc;
    end
  end

  // =============================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  por_load_a: assert property (state_q == rcf_pkg::RCF_CS_LOAD
    |=> osc_q == $past(cif.fuse_osc)) else $error("power-on source wrong");
  fixed_fuse_a: assert property (!cif.sw_en && (cif.brown_evt || cif.warm_evt)
    |=> osc_q == $past(cif.fuse_osc)) else $error("fuse source not taken");
  cold_fuse_a: assert property (cif.sw_en && cif.brown_evt
    |=> osc_q == $past(cif.fuse_osc)) else $error("brown-out source wrong");
  warm_keep_a: assert property (cif.sw_en && cif.warm_evt && !cif.brown_evt
    |=> osc_q == $past(cif.cur_osc)) else $error("warm reset lost source");
endmodule : rcf_clksel

// file: core/rcf_top.sv
// Purpose: reset cause flags, watchdog run control and clock source select
// Assumes: aresetn is the power-on reset; event inputs are one-cycle pulses on aclk
// Notes: the external reset pin is asynchronous and passes two flip-flops
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module rcf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic brownout_evt,
  input wire logic trap_conflict_evt,
  input wire logic illegal_op_evt,
  input wire logic cfg_mismatch_evt,
  input wire logic software_reset,
  input wire logic watchdog_timeout_reset,
  input wire logic power_saving_sleep_evt,
  input wire logic power_saving_idle_evt,
  input wire logic deep_sleep_enable,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_fuse_enable,
  input wire logic clk_switch_enable,
  input wire logic [2:0] new_osc_fuse_field,
  input wire logic [2:0] current_osc_field,
  output logic watchdog_run,
  output logic [2:0] osc_select,
  output logic [15:0] cause_flags
);
  rcf_reg_if rif ();
  rcf_clk_if cif ();

  logic [15:0] reset_cause_status_q;
  logic [15:0] reset_cause_status_d;
  logic [15:0] hw_set;
  logic [15:0] hw_clr;
  logic [15:0] wr_mask;
  logic pin_meta_q;
  logic pin_sync_q;
  logic ext_evt;
  logic power_saving_evt;
  logic cause_wr;
  logic watchdog_run_q;

  // =============================================================
  // address decode shared by the read and write sides
  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == rcf_pkg::OFF_CAUSE) || (addr == rcf_pkg::OFF_CLKSTAT);
  endfunction : reg_hit

  // =============================================================
  // bus slave
  rcf_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif)
  );

  // =============================================================
  // external reset pin synchroniser; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= !external_reset_pin_n;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign ext_evt = pin_sync_q;
  assign power_saving_evt = power_saving_sleep_evt || power_saving_idle_evt;

  // =============================================================
  // hardware set and clear vectors for the cause flags
  always_comb begin
    hw_set = 16'h0000;
    hw_set[rcf_pkg::B_BROWN] = brownout_evt;
    hw_set[rcf_pkg::B_TRAP] = trap_conflict_evt;
    hw_set[rcf_pkg::B_ILLOP] = illegal_op_evt;
    hw_set[rcf_pkg::B_CFGM] = cfg_mismatch_evt;
    hw_set[rcf_pkg::B_EXTR] = ext_evt;
    hw_set[rcf_pkg::B_SOFT_RST] = software_reset;
    hw_set[rcf_pkg::B_WDOG_TO] = watchdog_timeout_reset;
    hw_set[rcf_pkg::B_SLEEP] = power_saving_sleep_evt;
    hw_set[rcf_pkg::B_IDLE] = power_saving_idle_evt;
    hw_set[rcf_pkg::B_DEEP] = power_saving_sleep_evt && deep_sleep_enable;
    hw_clr = 16'h0000;
    hw_clr[rcf_pkg::B_WDOG_TO] = power_saving_evt;
  end

  // software write mask, low two byte lanes only
  assign cause_wr = rif.wr_en && (rif.wr_addr == rcf_pkg::OFF_CAUSE);
  assign wr_mask = cause_wr ? ({{8{rif.wstrb[1]}}, {8{rif.wstrb[0]}}} & rcf_pkg::CAUSE_MASK)
                            : 16'h0000;

  // next value: a hardware set wins over any clear in the same cycle
  always_comb begin
    reset_cause_status_d = reset_cause_status_q & ~hw_clr;
    reset_cause_status_d = (reset_cause_status_d & ~wr_mask)
                         | (rif.wdata[15:0] & wr_mask);
    reset_cause_status_d = (reset_cause_status_d | hw_set) & rcf_pkg::CAUSE_MASK;
  end

  // power-on reset is the only hardware clear of most flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_cause_status_q <= rcf_pkg::CAUSE_RST;
    end else begin
      reset_cause_status_q <= reset_cause_status_d;
    end
  end

  assign cause_flags = reset_cause_status_q;

  // =============================================================
  // watchdog run: the fuse overrides the software enable bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_run_q <= 1'b0;
    end else begin
      watchdog_run_q <= watchdog_fuse_enable
                     || reset_cause_status_q[rcf_pkg::B_SWDT];
    end
  end

  assign watchdog_run = watchdog_run_q;

  // =============================================================
  // clock source selection
  assign cif.brown_evt = brownout_evt;
  assign cif.warm_evt = ext_evt || watchdog_timeout_reset || software_reset;
  assign cif.sw_en = clk_switch_enable;
  assign cif.fuse_osc = new_osc_fuse_field;
  assign cif.cur_osc = current_osc_field;
  assign osc_select = cif.osc_sel;

  rcf_clksel u_clksel (
    .aclk(aclk),
    .aresetn(aresetn),
    .cif(cif)
  );

  // =============================================================
  // register read mux and decode answers; unmapped words read zero
  always_comb begin
    rif.rd_data = 32'h0000_0000;
    if (rif.rd_addr == rcf_pkg::OFF_CAUSE) begin
      rif.rd_data[15:0] = reset_cause_status_q;
    end else if (rif.rd_addr == rcf_pkg::OFF_CLKSTAT) begin
      rif.rd_data[rcf_pkg::B_OSC_LO +: 3] = cif.osc_sel;
      rif.rd_data[rcf_pkg::B_SWEN] = clk_switch_enable;
      rif.rd_data[rcf_pkg::B_WDRUN] = watchdog_run_q;
    end
  end

  // status word is read-only; writes to it are accepted and dropped
  assign rif.rd_ok = reg_hit(rif.rd_addr);
  assign rif.wr_ok = reg_hit(rif.wr_addr);

  // =============================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence sleep_req_s;
    power_saving_sleep_evt && deep_sleep_enable;
  endsequence

  sequence deep_set_s;
    reset_cause_status_q[rcf_pkg::B_DEEP] && reset_cause_status_q[rcf_pkg::B_SLEEP];
  endsequence

  sequence pin_low_s;
    !external_reset_pin_n ##1 !external_reset_pin_n ##1 !external_reset_pin_n;
  endsequence

  // no software write and no power-saving clear in this cycle
  sequence quiet_s;
    !cause_wr && !power_saving_evt;
  endsequence

  // =============================================================
  // checks: power-on value and software access

  // reset acts as power-on, so this one is watched while reset is low
  por_flags_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> reset_cause_status_q[1:0] == 2'b11) else $error("por flags missing");

  // nothing but reset or a write may move the power-on flag
  por_hold_a: assert property (!cause_wr
    |=> $stable(reset_cause_status_q[rcf_pkg::B_POR])) else $error("power-on flag moved");

  // a full write lands as written when no event touches the flags
  sw_write_a: assert property (cause_wr && rif.wstrb[1:0] == 2'b11 && hw_set == 16'h0000
    && !power_saving_evt
    |=> reset_cause_status_q == ($past(rif.wdata[15:0]) & rcf_pkg::CAUSE_MASK))
    else $error("software write not stored");

  // =============================================================
  // checks: watchdog run control

  // an unprogrammed fuse wins over the software bit
  wdt_force_a: assert property (watchdog_fuse_enable
    |=> watchdog_run) else $error("watchdog not forced on");

  // the software enable bit alone also runs it, one cycle late
  wdt_soft_a: assert property (reset_cause_status_q[rcf_pkg::B_SWDT]
    |=> watchdog_run) else $error("watchdog soft enable ignored");

  // with neither the fuse nor the bit the watchdog must stop
  wdt_idle_a: assert property (!watchdog_fuse_enable
    && !reset_cause_status_q[rcf_pkg::B_SWDT]
    |=> !watchdog_run) else $error("watchdog runs without enable");

  // =============================================================
  // checks: each event raises its own flag one edge later, the pin three low samples after it falls

  // brown-out sets its flag even against a clearing write
  brown_set_a: assert property (brownout_evt
    |=> reset_cause_status_q[rcf_pkg::B_BROWN]) else $error("brown-out flag lost");

  // trap conflict
  trap_wins_a: assert property (trap_conflict_evt
    |=> reset_cause_status_q[rcf_pkg::B_TRAP]) else $error("trap flag lost");

  // illegal opcode or uninitialised register access
  illop_set_a: assert property (illegal_op_evt
    |=> reset_cause_status_q[rcf_pkg::B_ILLOP]) else $error("illegal opcode flag lost");

  // configuration mismatch
  cfgm_set_a: assert property (cfg_mismatch_evt
    |=> reset_cause_status_q[rcf_pkg::B_CFGM]) else $error("config mismatch flag lost");

  // software reset instruction
  soft_rst_a: assert property (software_reset
    |=> reset_cause_status_q[rcf_pkg::B_SOFT_RST]) else $error("software reset flag lost");

  // watchdog expiry; the set wins over a power-saving clear
  wdog_set_a: assert property (watchdog_timeout_reset
    |=> reset_cause_status_q[rcf_pkg::B_WDOG_TO]) else $error("watchdog flag not set");

  // the pin passes two flip-flops, so three low samples are enough
  ext_pin_a: assert property (pin_low_s
    |=> reset_cause_status_q[rcf_pkg::B_EXTR]) else $error("pin reset flag missing");

  // power-saving instruction selecting sleep
  sleep_set_a: assert property (power_saving_sleep_evt
    |=> reset_cause_status_q[rcf_pkg::B_SLEEP]) else $error("sleep flag lost");

  // power-saving instruction selecting idle
  idle_set_a: assert property (power_saving_idle_evt
    |=> reset_cause_status_q[rcf_pkg::B_IDLE]) else $error("idle flag lost");

  // sleep with deep-sleep enabled raises both flags together
  deep_set_a: assert property (sleep_req_s |=> deep_set_s)
    else $error("deep-sleep flag missing");

  // =============================================================
  // checks: clears

  // without a write only the watchdog flag may ever fall
  sticky_hold_a: assert property (!cause_wr
    |=> (($past(reset_cause_status_q) & ~reset_cause_status_q)
         & ~(16'h0001 << rcf_pkg::B_WDOG_TO)) == 16'h0000)
    else $error("sticky flag cleared");

  // the watchdog flag falls only by the power-saving instruction or a write
  wdog_hold_a: assert property (quiet_s
    |=> !$fell(reset_cause_status_q[rcf_pkg::B_WDOG_TO])) else $error("watchdog flag fell");

  // the power-saving instruction clears the watchdog flag
  wdog_clr_a: assert property (power_saving_evt && !watchdog_timeout_reset && !cause_wr
    |=> !reset_cause_status_q[rcf_pkg::B_WDOG_TO]) else $error("watchdog flag not cleared");

  // sleep without the enable leaves the deep-sleep flag alone
  deep_hold_a: assert property (power_saving_sleep_evt && !deep_sleep_enable && !cause_wr
    |=> $stable(reset_cause_status_q[rcf_pkg::B_DEEP])) else $error("deep flag set wrongly");
endmodule : rcf_top

// file: dv/tb_top.sv
// Purpose: self-checking bench for the reset cause flags and clock select block
// Assumes: aresetn acts as power-on reset; bus answers are awaited, never timed
// Notes: ports are sampled mid-cycle so no check races the edge that drives them
`timescale 1ns/1ps
module tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, wd_run;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] ev = 8'h00;
  logic pin_n = 1, dse = 0, wfuse = 0, csw = 0;
  logic [2:0] nfuse = 3'h5;
  logic [2:0] cur = 3'h2;
  logic [2:0] osc, osc_s;
  logic run_s;
  logic [15:0] flags, flags_s;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  // flag position for each event line, index 8 is the external pin
  int bits [9] = '{rcf_pkg::B_BROWN, rcf_pkg::B_TRAP, rcf_pkg::B_ILLOP, rcf_pkg::B_CFGM,
    rcf_pkg::B_SOFT_RST, rcf_pkg::B_WDOG_TO, rcf_pkg::B_SLEEP, rcf_pkg::B_IDLE, rcf_pkg::B_EXTR};

  rcf_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .brownout_evt(ev[0]), .trap_conflict_evt(ev[1]),
    .illegal_op_evt(ev[2]), .cfg_mismatch_evt(ev[3]), .software_reset(ev[4]),
    .watchdog_timeout_reset(ev[5]), .power_saving_sleep_evt(ev[6]),
    .power_saving_idle_evt(ev[7]),
    .deep_sleep_enable(dse), .external_reset_pin_n(pin_n), .watchdog_fuse_enable(wfuse),
    .clk_switch_enable(csw), .new_osc_fuse_field(nfuse), .current_osc_field(cur),
    .watchdog_run(wd_run), .osc_select(osc), .cause_flags(flags));

  // =============================================================
  // clock and hang guard
  always #50 aclk = ~aclk;

  // a hang counts as a mismatch; the whole sequence needs well under 1000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  // =============================================================
  // tasks
  task automatic finish_test;
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // readies are sampled mid-cycle; inputs only move right after rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    hb = 0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid & bready;
      rs = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 0;
      if (hw) wvalid <= 0;
    end
    bready <= 0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    hr = 0;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid & rready;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 0;
    end
    rready <= 0;
    @(posedge aclk);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk("read data", e, d);
    chk("read resp", 32'(rcf_pkg::RESP_OKAY), 32'(r));
  endtask : rdchk

  // snapshot of the plain outputs, taken where they are settled
  task automatic look;
    @(negedge aclk);
    osc_s = osc;
    run_s = wd_run;
    flags_s = flags;
    @(posedge aclk);
  endtask : look

  // one-cycle event pulse, or the pin held low long enough to pass the synchroniser
  task automatic fire(input int i);
    if (i < 8) begin
      ev[i] <= 1;
      @(posedge aclk);
      ev[i] <= 0;
    end else begin
      pin_n <= 0;
      repeat (4) @(posedge aclk);
      pin_n <= 1;
    end
    repeat (3) @(posedge aclk);
  endtask : fire

  task automatic osc_is(input logic [2:0] e);
    look();
    chk("osc_select", 32'(e), 32'(osc_s));
  endtask : osc_is

  // =============================================================
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdchk(8'h00, 32'h0003);
    osc_is(3'h5);
    // software sets every flag; a reset would have brought back 0x0003
    wr(8'h00, 32'hFFFF, r);
    chk("write resp", 32'(rcf_pkg::RESP_OKAY), 32'(r));
    rdchk(8'h00, 32'(rcf_pkg::CAUSE_MASK));
    look();
    chk("cause_flags", 32'(rcf_pkg::CAUSE_MASK), 32'(flags_s));
    chk("watchdog_run", 32'h1, 32'(run_s));
    wr(8'h00, 32'h0, r);
    look();
    chk("watchdog_run", 32'h0, 32'(run_s));
    wfuse <= 1;
    look();
    look();
    chk("watchdog_run", 32'h1, 32'(run_s));
    wfuse <= 0;
    // each event line sets its own flag and nothing else
    for (int i = 0; i < 9; i++) begin
      fire(i);
      rdchk(8'h00, 32'h1 << bits[i]);
      wr(8'h00, 32'h0, r);
    end
    // watchdog flag is cleared by the power-saving instruction
    fire(5);
    fire(7);
    rdchk(8'h00, 32'h0004);
    wr(8'h00, 32'h0, r);
    fire(5);
    dse <= 1;
    fire(6);
    rdchk(8'h00, 32'h0408);
    dse <= 0;
    wr(8'h00, 32'h0, r);
    fire(6);
    rdchk(8'h00, 32'h0008);
    // clock source after each kind of reset with switching enabled, then a software reset with it disabled
    csw <= 1;
    fire(4);
    osc_is(3'h2);
    cur <= 3'h3;
    fire(5);
    osc_is(3'h3);
    fire(0);
    osc_is(3'h5);
    cur <= 3'h4;
    fire(8);
    osc_is(3'h4);
    rdchk(8'h04, 32'h0014);
    csw <= 0;
    fire(4);
    osc_is(3'h5);
    // unmapped places answer with a decode error and change nothing
    rd(8'h08, d, r);
    chk("unmapped read resp", 32'(rcf_pkg::RESP_DECERR), 32'(r));
    chk("unmapped read data", 32'h0, d);
    wr(8'h00, 32'h0, r);
    wr(8'h0C, 32'hFFFF, r);
    chk("unmapped write resp", 32'(rcf_pkg::RESP_DECERR), 32'(r));
    rdchk(8'h00, 32'h0000);
    // second power-on in mid-run, switching enabled
    wr(8'h00, 32'h8780, r);
    csw <= 1;
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdchk(8'h00, 32'h0003);
    osc_is(3'h5);
    finish_test();
  end
endmodule : tb_top
